/* hw/rad_regs.svh */
// Constants for the RS485 automatic direction control block
`ifndef RAD_REGS_SVH
`define RAD_REGS_SVH

// ****************************************************************
// Clocks and rates
// ****************************************************************
`define RAD_CLK_PERIOD_NS   10            // System clock period, 10 ns
`define RAD_SYS_HZ          32'h05F5E100  // 100 MHz system clock
`define RAD_REF_STD_HZ      32'h001C2000  // 1.8432MHz standard reference
`define RAD_REF_FAST_HZ     32'h00708000  // 7.3728MHz fast reference
`define RAD_MAX_BAUD_STD    32'h0001C200  // 115,200 baud ceiling, standard clock
`define RAD_MAX_BAUD_FAST   32'h00070800  // 460,800 baud ceiling, fast clock

// ****************************************************************
// Frame timing, word length and queue depth
// ****************************************************************
`define RAD_OVERSAMPLE      9'h010        // Ticks of the 16x clock per bit
`define RAD_HALF_BIT        9'h008        // Half a bit, for a 1.5 stop interval
`define RAD_FIFO_DEPTH      16            // Bytes in each queue
`define RAD_DATA_BITS_MIN   4'h5          // Word length code 0 means five bits

`endif

/* hw/rad_pkg.sv */
// Types shared by the RS485 automatic direction control block
`default_nettype none
package rad_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [7:0] rad_byte_t;

  typedef enum logic [1:0] {
    DIR_IDLE,
    DIR_XMIT,
    DIR_HOLD
  } rad_dir_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rad_rx_t;

endpackage : rad_pkg
`default_nettype wire

/* hw/rad_fifo.sv */
// Byte queue built from flip-flops with registered full and empty flags
`timescale 1ns/1ps
`default_nettype none
`include "rad_regs.svh"

module rad_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `RAD_FIFO_DEPTH
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             rstn,     // Async reset, active low
  input  wire logic             push,     // Write strobe
  input  wire logic [WIDTH-1:0] wrData,   // Write data
  input  wire logic             pop,      // Read strobe
  output logic      [WIDTH-1:0] rdData,   // Head entry
  output logic                  full,     // Queue full
  output logic                  empty     // Queue empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             full_q;
  logic             empty_q;
  logic             doPush;
  logic             doPop;

  // Strobes against a full or empty queue are dropped
  assign doPush = push && !full_q;
  assign doPop  = pop && !empty_q;
  assign rdData = mem[rdPtr_q];
  assign full   = full_q;
  assign empty  = empty_q;

  // Storage has no reset; only the pointers define validity
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_q] <= wrData;
    end
  end

  // Pointers, count and flags move together
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
      end
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
      end
      if (doPush && !doPop) begin
        count_q <= count_q + (AW+1)'(1);
        full_q  <= (count_q == (AW+1)'(DEPTH - 1));
        empty_q <= 1'b0;
      end else if (doPop && !doPush) begin
        count_q <= count_q - (AW+1)'(1);
        full_q  <= 1'b0;
        empty_q <= (count_q == (AW+1)'(1));
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_FIFO_FULL_AT_DEPTH: assert property (full_q == (count_q == (AW+1)'(DEPTH)))
    else $error("full flag disagrees with queue depth");
  AST_FIFO_NO_OVERRUN: assert property (full_q && push && !pop |=> $stable(count_q))
    else $error("write into full queue changed its count");

endmodule : rad_fifo
`default_nettype wire

/* hw/rad_dir_ctrl.sv */
// Serial controller with queues and automatic RS485 driver and receiver control
`timescale 1ns/1ps
`default_nettype none
`include "rad_regs.svh"

module rad_dir_ctrl (
  input  wire logic              clk_sys,    // System clock, 100 MHz
  input  wire logic              rstn,       // Async reset, active low
  input  wire rad_pkg::rad_byte_t txData,    // Byte to send
  input  wire logic              txWrite,    // Queue txData, one-cycle pulse
  output logic                   txFull,     // Transmit queue full
  output rad_pkg::rad_byte_t     rxData,     // Received byte
  output logic                   rxValid,    // rxData holds a byte
  input  wire logic              rxReady,    // Consumer takes rxData
  input  wire logic [15:0]       divisor,    // Baud divisor, 0 acts as 1
  input  wire logic [1:0]        wordLen,    // 0..3 means 5..8 data bits
  input  wire logic              parityEn,   // Parity bit present
  input  wire logic              parityEven, // Even parity when set
  input  wire logic              stopTwo,    // Two stop bits, 1.5 for five bits
  input  wire logic              clkMulSel,  // Fast reference clock option pin
  input  wire logic              rxd,        // Line receiver output
  output logic                   txd,        // Line driver input
  output logic                   driverEn,   // Line driver enable, active high
  output logic                   rcvEn       // Line receiver enable, active high
);
  import rad_pkg::*;

  // ****************************************************************
  // Frame arithmetic
  // ****************************************************************
  function automatic logic [3:0] frameBits(input logic [1:0] wl, input logic pe,
                                           input logic st);
    frameBits = 4'h1 + `RAD_DATA_BITS_MIN + {2'b00, wl} + {3'b000, pe} + (st ? 4'h2 : 4'h1);
  endfunction : frameBits

  function automatic logic [8:0] frameTicks(input logic [1:0] wl, input logic pe,
                                            input logic st);
    logic [8:0] t;
    t = {5'h00, frameBits(wl, pe, st)} << 4;
    if (st && wl == 2'b00) begin
      t = t - `RAD_HALF_BIT;
    end
    frameTicks = t;
  endfunction : frameTicks

  rad_dir_t   dir_q;
  rad_rx_t    rxState_q;
  logic       mulMeta_q, mulSync_q, rxMeta_q, rxSync_q;
  logic [31:0] refAcc_q;
  logic       refTick_q, tick_q;
  logic [15:0] divCnt_q;
  logic       driverEn_q, rcvEn_q, txd_q;
  logic [8:0] holdCnt_q;
  logic [11:0] txSh_q;
  logic [3:0] txBitsLeft_q;
  logic [4:0] txTick_q;
  logic       txBusy_q;
  logic [3:0] rxBit_q, rxTick_q;
  rad_byte_t  rxSh_q, rxData_q;
  logic       rxValid_q, rxPush;
  rad_byte_t  txHead, rxHead, mask;
  logic       txEmpty, txFullW, rxEmpty, txPop, rxPop;
  logic [11:0] txFrame;
  logic [31:0] refStep, refSum;
  logic [15:0] divLim;
  logic [3:0] nData;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mulMeta_q <= 1'b0;
      mulSync_q <= 1'b0;
      rxMeta_q  <= 1'b1;
      rxSync_q  <= 1'b1;
    end else begin
      mulMeta_q <= clkMulSel;
      mulSync_q <= mulMeta_q;
      rxMeta_q  <= rxd;
      rxSync_q  <= rxMeta_q;
    end
  end

  // ****************************************************************
  // Reference and 16x baud clock
  // ****************************************************************
  // Fractional accumulator stands in for the card oscillator; jitter is one sys cycle
  assign refStep = mulSync_q ? `RAD_REF_FAST_HZ : `RAD_REF_STD_HZ;
  assign refSum  = refAcc_q + refStep;
  assign divLim  = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      refAcc_q  <= 32'h00000000;
      refTick_q <= 1'b0;
    end else if (refSum >= `RAD_SYS_HZ) begin
      refAcc_q  <= refSum - `RAD_SYS_HZ;
      refTick_q <= 1'b1;
    end else begin
      refAcc_q  <= refSum;
      refTick_q <= 1'b0;
    end
  end

  // Divisor counter gives the 16x tick that every bit and the hold-off count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= 16'h0000;
      tick_q   <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (refTick_q) begin
        if (divCnt_q >= divLim) begin
          divCnt_q <= 16'h0000;
          tick_q   <= 1'b1;
        end else begin
          divCnt_q <= divCnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Queues
  // ****************************************************************
  rad_fifo #(.WIDTH(8), .DEPTH(`RAD_FIFO_DEPTH)) txQueue (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .push    (txWrite),
    .wrData  (txData),
    .pop     (txPop),
    .rdData  (txHead),
    .full    (txFullW),
    .empty   (txEmpty)
  );

  rad_fifo #(.WIDTH(8), .DEPTH(`RAD_FIFO_DEPTH)) rxQueue (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .push    (rxPush),
    .wrData  (rxSh_q & mask),
    .pop     (rxPop),
    .rdData  (rxHead),
    .full    (),
    .empty   (rxEmpty)
  );

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  assign nData = `RAD_DATA_BITS_MIN + {2'b00, wordLen};
  assign mask  = 8'hFF >> (4'h8 - nData);
  assign txPop = dir_q == DIR_XMIT && driverEn_q && !txBusy_q && !txEmpty;

  // Frame image: start bit low, data LSB first, optional parity, stop ones
  always_comb begin
    txFrame    = 12'hFFF;
    txFrame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nData) begin
        txFrame[i+1] = txHead[i];
      end
    end
    if (parityEn) begin
      txFrame[nData+4'h1] = (^(txHead & mask)) ^ !parityEven;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txSh_q       <= 12'hFFF;
      txBitsLeft_q <= 4'h0;
      txTick_q     <= 5'h00;
      txBusy_q     <= 1'b0;
      txd_q        <= 1'b1;
    end else begin
      txd_q <= txBusy_q ? txSh_q[0] : 1'b1;
      if (txPop) begin
        txSh_q       <= txFrame;
        txBitsLeft_q <= frameBits(wordLen, parityEn, stopTwo) - 4'h1;
        txTick_q     <= 5'h0F;
        txBusy_q     <= 1'b1;
      end else if (txBusy_q && tick_q) begin
        if (txTick_q != 5'h00) begin
          txTick_q <= txTick_q - 5'h01;
        end else if (txBitsLeft_q == 4'h0) begin
          txBusy_q <= 1'b0;
        end else begin
          txSh_q       <= {1'b1, txSh_q[11:1]};
          txBitsLeft_q <= txBitsLeft_q - 4'h1;
          // Second stop bit of a five-bit frame lasts half a bit, giving 1.5 stops
          txTick_q <= (txBitsLeft_q == 4'h1 && stopTwo && wordLen == 2'b00) ? 5'h07 : 5'h0F;
        end
      end
    end
  end

  // ****************************************************************
  // Direction control
  // ****************************************************************
  // Driver and receiver flip in the same edge so the pair is never both on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dir_q      <= DIR_IDLE;
      driverEn_q <= 1'b0;
      rcvEn_q    <= 1'b1;
      holdCnt_q  <= 9'h000;
    end else begin
      unique case (dir_q)
        DIR_IDLE: begin
          if (!txEmpty) begin
            dir_q      <= DIR_XMIT;
            driverEn_q <= 1'b1;
            rcvEn_q    <= 1'b0;
          end
        end
        DIR_XMIT: begin
          if (!txBusy_q && txEmpty) begin
            dir_q     <= DIR_HOLD;
            holdCnt_q <= frameTicks(wordLen, parityEn, stopTwo) - 9'h001;
          end
        end
        DIR_HOLD: begin
          if (!txEmpty) begin
            dir_q <= DIR_XMIT;
          end else if (tick_q) begin
            if (holdCnt_q == 9'h000) begin
              dir_q      <= DIR_IDLE;
              driverEn_q <= 1'b0;
              rcvEn_q    <= 1'b1;
            end else begin
              holdCnt_q <= holdCnt_q - 9'h001;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  // A muted receiver abandons any frame; our own echo is never queued
  assign rxPush = rxState_q == RX_STOP && tick_q && rxTick_q == 4'h0 && rxSync_q && rcvEn_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxState_q <= RX_IDLE;
      rxBit_q   <= 4'h0;
      rxTick_q  <= 4'h0;
      rxSh_q    <= 8'h00;
    end else if (!rcvEn_q) begin
      rxState_q <= RX_IDLE;
    end else if (tick_q) begin
      rxTick_q <= rxTick_q - 4'h1;
      unique case (rxState_q)
        RX_IDLE: begin
          if (!rxSync_q) begin
            rxState_q <= RX_START;
            rxTick_q  <= 4'h7;
          end
        end
        RX_START: begin
          if (rxTick_q == 4'h0) begin
            rxState_q <= rxSync_q ? RX_IDLE : RX_DATA;
            rxTick_q  <= 4'hF;
            rxBit_q   <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rxTick_q == 4'h0) begin
            if (rxBit_q < 4'h8) begin
              rxSh_q[rxBit_q[2:0]] <= rxSync_q;
            end
            rxBit_q  <= rxBit_q + 4'h1;
            rxTick_q <= 4'hF;
            if (rxBit_q == nData + {3'b000, parityEn} - 4'h1) begin
              rxState_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rxTick_q == 4'h0) begin
            rxState_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Output stage keeps rxData and rxValid straight from flip-flops
  assign rxPop = !rxEmpty && (!rxValid_q || rxReady);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxData_q  <= 8'h00;
      rxValid_q <= 1'b0;
    end else if (rxPop) begin
      rxData_q  <= rxHead;
      rxValid_q <= 1'b1;
    end else if (rxReady) begin
      rxValid_q <= 1'b0;
    end
  end

  assign txFull   = txFullW;
  assign rxData   = rxData_q;
  assign rxValid  = rxValid_q;
  assign txd      = txd_q;
  assign driverEn = driverEn_q;
  assign rcvEn    = rcvEn_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence seqLastOut;
    dir_q == DIR_XMIT && !txBusy_q && txEmpty;
  endsequence
  sequence seqHoldEnd;
    dir_q == DIR_HOLD && txEmpty && tick_q && holdCnt_q == 9'h000;
  endsequence

  AST_DRV_ON_DEMAND: assert property (dir_q == DIR_IDLE && !txEmpty |=> driverEn_q)
    else $error("driver not enabled for pending data");
  AST_HOLD_LENGTH: assert property (seqLastOut |=> dir_q == DIR_HOLD && driverEn_q
      && holdCnt_q == frameTicks(wordLen, parityEn, stopTwo) - 9'h001)
    else $error("hold-off not loaded with one frame");
  AST_DRV_OFF_AFTER: assert property (seqHoldEnd |=> !driverEn_q && rcvEn_q)
    else $error("driver not released after hold-off");
  AST_RCV_MUTED: assert property (driverEn_q |-> !rcvEn_q)
    else $error("receiver on while driving");
  AST_HOLD_TRACKS: assert property (dir_q == DIR_HOLD && !tick_q && txEmpty
      |=> $stable(holdCnt_q))
    else $error("hold-off moved without a baud tick");
  AST_ONE_TALKER: assert property (!rcvEn_q |=> rxState_q == RX_IDLE && !rxPush)
    else $error("receiver active while the line is ours");
  AST_RESTART_HOLD: assert property (dir_q == DIR_HOLD && !txEmpty
      |=> dir_q == DIR_XMIT && driverEn_q)
    else $error("new data did not restart transmission");
  AST_LINE_IDLE: assert property (dir_q == DIR_IDLE && !txBusy_q |=> txd_q)
    else $error("line not marking while idle");

endmodule : rad_dir_ctrl
`default_nettype wire

/* dv/rad_line_partner.sv */
// Model of a remote terminal sharing the differential pair with the block
`timescale 1ns/1ps
`default_nettype none

module rad_line_partner (
  input  wire logic txd,      // Block's driver input
  input  wire logic driverEn, // Block drives the pair
  output logic      rxd       // Pair level seen by the block's receiver
);
  real        bitNs  = 2170.0; // Bit time, set by the bench
  int         nBits  = 8;      // Data plus parity bits per frame
  logic [9:0] got[$];          // Frames heard, bit 0 first, then stop
  logic       drv    = 1'b0;   // Remote driver on
  logic       bitOut = 1'b1;   // Remote driver level

  // Bias pulls an undriven pair to one; the block hears its own echo
  assign rxd = driverEn ? txd : (drv ? bitOut : 1'b1);

  // Listen to the block's frames, sampling each bit at its middle
  always begin : listen
    logic [9:0] f;
    f = 10'h3FF;
    @(negedge txd iff driverEn === 1'b1);
    #(bitNs * 1.5);
    for (int i = 0; i < nBits; i++) begin
      f[i] = txd;
      #(bitNs);
    end
    f[nBits] = txd;
    got.push_back(f);
  end

  // Send one frame; waits for the block to let go of the pair first
  task automatic send(input logic [9:0] f);
    wait (driverEn === 1'b0);
    drv = 1'b1;
    bitOut = 1'b0;
    #(bitNs);
    for (int i = 0; i <= nBits; i++) begin
      bitOut = f[i];
      #(bitNs);
    end
    drv = 1'b0;
    bitOut = 1'b1;
  endtask : send
endmodule : rad_line_partner
`default_nettype wire

/* dv/tb_rs485_auto_direction_control.sv */
// Self-checking bench for the automatic direction control block
`timescale 1ns/1ps
`default_nettype none

module tb_rs485_auto_direction_control;
  import rad_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn;
  rad_byte_t   txData  = 8'h00;
  logic        txWrite = 1'b0;
  logic        rxReady = 1'b0;
  logic [15:0] divisor = 16'h0001;
  logic [1:0]  wordLen = 2'h3;
  logic        parityEn = 1'b0;
  logic        parityEven = 1'b0;
  logic        stopTwo = 1'b0;
  logic        clkMulSel = 1'b1;
  logic        rxd;
  logic        txFull, rxValid, txd, driverEn, rcvEn;
  rad_byte_t   rxData;
  int          errors = 0;
  int          totalChecks = 0;
  int          rises = 0;
  int          nb;
  real         bitC, frm;

  // ****************************************************************
  // Design, far side and clock
  // ****************************************************************
  // The bench plays the host, driving the byte and configuration ports directly
  rad_dir_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .txData(txData), .txWrite(txWrite),
    .txFull(txFull), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .divisor(divisor), .wordLen(wordLen), .parityEn(parityEn), .parityEven(parityEven),
    .stopTwo(stopTwo), .clkMulSel(clkMulSel), .rxd(rxd), .txd(txd), .driverEn(driverEn),
    .rcvEn(rcvEn));
  rad_line_partner peer (.txd(txd), .driverEn(driverEn), .rxd(rxd));
  always #5 clk_sys = ~clk_sys;

  // Receiver must be exactly the inverse of the driver, away from the edge
  always @(negedge clk_sys) if (rstn === 1'b1 && rcvEn !== ~driverEn) fail("direction clash");
  // Count driver switch-ons to spot a gap between characters
  always @(posedge driverEn) rises++;

  // ****************************************************************
  // Compare and helper tasks
  // ****************************************************************
  task automatic fail(input string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : fail

  task automatic cmpBit(input logic g, input logic e, input string m);
    totalChecks++;
    if (g !== e) fail(m);
  endtask : cmpBit

  task automatic cmpVal(input logic [9:0] g, input logic [9:0] e, input string m);
    totalChecks++;
    if (g !== e) fail(m);
  endtask : cmpVal

  task automatic cmpNum(input real g, input real e, input real tol, input string m);
    totalChecks++;
    if (g < e - tol || g > e + tol) fail(m);
  endtask : cmpNum

  task automatic stop_test();
    if (errors == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // Frame as heard on the pair: data LSB first, parity, then ones
  function automatic logic [9:0] expFrame(input rad_byte_t b);
    logic [9:0] f;
    rad_byte_t  d;
    f = 10'h3FF;
    d = b & (8'hFF >> (3 - wordLen));
    for (int i = 0; i < 5 + wordLen; i++) f[i] = d[i];
    if (parityEn) f[nb - 1] = parityEven ? ^d : ~^d;
    return f;
  endfunction : expFrame

  // Frame format and rate; bit time follows reference and divisor
  task automatic setCfg(input logic [1:0] wl, input logic pe, input logic pev,
                        input logic st, input logic mul, input logic [15:0] dv);
    @(posedge clk_sys);
    wordLen <= wl;
    parityEn <= pe;
    parityEven <= pev;
    stopTwo <= st;
    clkMulSel <= mul;
    divisor <= dv;
    nb = 5 + wl + pe;
    bitC = 16.0 * dv * 1.0e8 / (mul ? 7372800.0 : 1843200.0);
    frm = 1.0 + nb + (st ? ((wl == 2'h0) ? 1.5 : 2.0) : 1.0);
    peer.nBits = nb;
    peer.bitNs = bitC * 10.0;
    repeat (4) @(posedge clk_sys);
  endtask : setCfg

  task automatic writeByte(input rad_byte_t b);
    @(posedge clk_sys);
    txData <= b;
    txWrite <= 1'b1;
    @(posedge clk_sys);
    txWrite <= 1'b0;
  endtask : writeByte

  // Bounded wait for the driver to switch off, in cycles
  task automatic waitFall(output int c);
    c = 0;
    while (driverEn === 1'b1 && c < 400000) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
  endtask : waitFall

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_tx(input rad_byte_t b);
    int c;
    peer.got.delete();
    writeByte(b);
    #1 cmpBit(driverEn, 1'b0, "driver on too early");
    @(posedge clk_sys);
    #1 cmpBit(driverEn, 1'b1, "driver not on");
    cmpBit(rcvEn, 1'b0, "receiver not muted");
    waitFall(c);
    cmpNum(c, 2.0 * frm * bitC, bitC / 2.0, "driver time off");
    cmpBit(rcvEn, 1'b1, "receiver not back");
    cmpNum(peer.got.size(), 1, 0, "frame count");
    if (peer.got.size() > 0) cmpVal(peer.got[0], expFrame(b), "frame bits");
    cmpBit(rxValid, 1'b0, "own echo received");
  endtask : t_tx

  task automatic t_b2b();
    int c;
    int r;
    peer.got.delete();
    writeByte(8'hA5);
    c = 0;
    while (peer.got.size() == 0 && c < 100000) begin
      @(posedge clk_sys);
      c++;
    end
    // Land the second byte well inside the hold-off, so only a full restart fits
    repeat (int'(3.0 * bitC)) @(posedge clk_sys);
    r = rises;
    writeByte(8'h3C);
    #1 waitFall(c);
    cmpNum(rises, r, 0, "driver dropped between bytes");
    cmpNum(c, 2.0 * frm * bitC, bitC / 2.0, "hold not restarted");
    cmpNum(peer.got.size(), 2, 0, "frame count");
  endtask : t_b2b

  task automatic t_rx();
    int c;
    peer.send(expFrame(8'h5A));
    c = 0;
    while (rxValid !== 1'b1 && c < 5000) begin
      @(posedge clk_sys);
      c++;
    end
    #1 cmpBit(rxValid, 1'b1, "no byte received");
    cmpVal({2'b00, rxData}, 10'h05A, "received byte");
    @(posedge clk_sys);
    rxReady <= 1'b1;
    @(posedge clk_sys);
    rxReady <= 1'b0;
    @(posedge clk_sys);
    #1 cmpBit(rxValid, 1'b0, "byte not taken");
  endtask : t_rx

  // Seventeen bytes fill the queue while one shifts; an eighteenth is dropped
  task automatic t_fill();
    int c;
    peer.got.delete();
    @(posedge clk_sys);
    txWrite <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      txData <= 8'(i);
      @(posedge clk_sys);
    end
    txWrite <= 1'b0;
    @(posedge clk_sys);
    #1 cmpBit(txFull, 1'b1, "queue not full");
    @(posedge clk_sys);
    txData <= 8'h0E;
    txWrite <= 1'b1;
    @(posedge clk_sys);
    txWrite <= 1'b0;
    #1 waitFall(c);
    cmpBit(txFull, 1'b0, "queue still full");
    cmpNum(peer.got.size(), 17, 0, "queued frame count");
    if (peer.got.size() == 17) cmpVal(peer.got[16], expFrame(8'h10), "last frame");
  endtask : t_fill

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1 cmpBit(txd, 1'b1, "txd after reset");
    cmpBit(driverEn, 1'b0, "driver after reset");
    cmpBit(rcvEn, 1'b1, "receiver after reset");
    cmpBit(txFull, 1'b0, "full after reset");
    cmpVal({1'b0, rxValid, rxData}, 10'h000, "receive side after reset");
    setCfg(2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0001);
    t_tx(8'hC5);
    setCfg(2'h0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0001);
    t_tx(8'h13);
    setCfg(2'h1, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0001);
    t_tx(8'h2E);
    setCfg(2'h2, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0001);
    t_tx(8'h55);
    t_rx();
    setCfg(2'h2, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0002);
    t_tx(8'h0F);
    setCfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0001);
    t_tx(8'h1B);
    setCfg(2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0001);
    t_b2b();
    setCfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0001);
    t_fill();
    stop_test();
  end

  // The sequence takes about 0.8 ms; a full millisecond means a hang
  initial begin
    #1000000;
    fail("watchdog expired");
    stop_test();
  end
endmodule : tb_rs485_auto_direction_control
`default_nettype wire
